// ==== lsir_pkg.sv ====
// Shared constants and types for the latched status and interrupt register bank
package lsir_pkg;

  // Framers sharing the control port and the interrupt line
  localparam int          LSIR_NUM_FRAMERS   = 4;
  localparam int          LSIR_NUM_LATCHED   = 4;

  // Register offsets on the parallel control port
  localparam logic [7:0]  LSIR_ADDR_STAT1    = 8'h20;
  localparam logic [7:0]  LSIR_ADDR_STAT2    = 8'h21;
  localparam logic [7:0]  LSIR_ADDR_RXINFO1  = 8'h22;
  localparam logic [7:0]  LSIR_ADDR_RXINFO2  = 8'h31;
  localparam logic [7:0]  LSIR_ADDR_MASK1    = 8'h7F;
  localparam logic [7:0]  LSIR_ADDR_MASK2    = 8'h6F;

  // Reset values
  localparam logic [7:0]  LSIR_RST_LATCH     = 8'h00;
  localparam logic [7:0]  LSIR_RST_COPY      = 8'h00;
  localparam logic [7:0]  LSIR_RST_MASK      = 8'h00;

  // Field positions in the second receive information register
  localparam int          LSIR_RXI2_RX_PDV   = 1;
  localparam int          LSIR_RXI2_TX_PDV   = 0;
  localparam int          LSIR_RXI2_EXT_LSB  = 2;
  localparam int          LSIR_RXI2_EXT_W    = 6;

  // Pulse density limits: ones window is UNIT*(N+1) bits for N = 1..MAX_N
  localparam int          LSIR_PD_MAX_N      = 23;
  localparam int          LSIR_PD_WIN_UNIT   = 8;
  localparam int          LSIR_PD_MAX_ZEROS  = 15;
  localparam logic [7:0]  LSIR_PD_AGE_SAT    = 8'hFF;

  // Register selected by an address
  typedef enum logic [2:0] {
    LSIR_SEL_STAT1   = 3'b000,
    LSIR_SEL_STAT2   = 3'b001,
    LSIR_SEL_RXINFO1 = 3'b010,
    LSIR_SEL_RXINFO2 = 3'b011,
    LSIR_SEL_MASK1   = 3'b100,
    LSIR_SEL_MASK2   = 3'b101,
    LSIR_SEL_SUMMARY = 3'b110
  } lsir_sel_t;

endpackage

// ==== lsir_density_chk.sv ====
// Ones density monitor for one serial data stream
`timescale 1ns/10ps
module lsir_density_chk
  import lsir_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  // Serial stream, one bit per strobe
  input  wire logic bit_en_i,
  input  wire logic bit_i,
  // Violation flag, high for the cycle after each violating bit; back-to-back violating bits keep it high
  output logic      viol_o
);

  // Age in bits of the most recent ones; entry 0 is the newest one.
  // Starting at zero treats the stream as dense, so no false alarm at start-up.
  logic [7:0] age_r   [LSIR_PD_MAX_N];
  logic [7:0] age_nxt [LSIR_PD_MAX_N];
  logic       viol_r;
  logic       viol_nxt;

  function automatic logic [7:0] sat_inc(input logic [7:0] a);
    sat_inc = (a == LSIR_PD_AGE_SAT) ? a : a + 8'h01;
  endfunction

  always_comb begin
    viol_nxt = 1'b0;
    for (int j = 0; j < LSIR_PD_MAX_N; j++) begin
      age_nxt[j] = age_r[j];
    end
    if (bit_en_i) begin
      // A new one becomes entry 0 and pushes the older ones down the list
      age_nxt[0] = bit_i ? 8'h00 : sat_inc(age_r[0]);
      for (int j = 1; j < LSIR_PD_MAX_N; j++) begin
        age_nxt[j] = bit_i ? sat_inc(age_r[j-1]) : sat_inc(age_r[j]);
      end
      // The N-th newest one older than the window means fewer than N ones in it;
      // N = 1 gives the run of more than fifteen zeros
      for (int n = 1; n <= LSIR_PD_MAX_N; n++) begin
        if (age_nxt[n-1] >= 8'(LSIR_PD_WIN_UNIT * (n + 1))) begin
          viol_nxt = 1'b1; // R15
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int j = 0; j < LSIR_PD_MAX_N; j++) begin
        age_r[j] <= 8'h00;
      end
      viol_r <= 1'b0;
    end else begin
      for (int j = 0; j < LSIR_PD_MAX_N; j++) begin
        age_r[j] <= age_nxt[j];
      end
      viol_r <= viol_nxt;
    end
  end

  assign viol_o = viol_r;

endmodule

// ==== lsir_regs.sv ====
// Latched status, receive information, mask and summary registers of four framers
`timescale 1ns/10ps

// Overview of operation
// R1: Status and info bits latch on events
// R2: Cleared bit returns only on new event
// R3: Mask one refreshes copy, clears latch
// R4: Mask zero keeps previous readable copy
// R5: Host writes mask, then reads register
// R6: Host writes back read AND mask
// R7: Mask-clear scheme only for four registers
// R8: Only status registers drive shared interrupt
// R9: Mask registers gate each status flag
// R10: Summary at unused addresses, two bits/framer
// R11: Receive buffer full flag on deletion
// R12: Transmit buffer full flag on deletion
// R13: Receive density violation sets bit one
// R14: Transmit density violation sets bit zero
// R15: Density rule: zeros run, ones windows
// R16: Interrupt low while unmasked flag latched
// R17: Other info flags latch own events
module lsir_regs
  import lsir_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Parallel control port
  input  wire logic        cs_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [1:0]  fs_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             rdata_oe_o,
  // Framer events, eight bits per framer, framer 0 in the low byte
  input  wire logic [31:0] stat1_evt_i,
  input  wire logic [31:0] stat2_evt_i,
  input  wire logic [31:0] rxinfo1_evt_i,
  // Upper six events of the second info register, six bits per framer
  input  wire logic [23:0] rxinfo2_evt_i,
  // Serial streams for the density monitors, one bit per framer
  input  wire logic [3:0]  rx_bit_en_i,
  input  wire logic [3:0]  rx_bit_i,
  input  wire logic [3:0]  tx_bit_en_i,
  input  wire logic [3:0]  tx_bit_i,
  // Shared open-drain interrupt, active low
  output logic             irq_n_o,
  output logic             irq_n_oe_o
);

  logic [7:0] latch_r   [LSIR_NUM_FRAMERS][LSIR_NUM_LATCHED];
  logic [7:0] latch_nxt [LSIR_NUM_FRAMERS][LSIR_NUM_LATCHED];
  logic [7:0] copy_r    [LSIR_NUM_FRAMERS][LSIR_NUM_LATCHED];
  logic [7:0] copy_nxt  [LSIR_NUM_FRAMERS][LSIR_NUM_LATCHED];
  logic [7:0] mask_r    [LSIR_NUM_FRAMERS][2];
  logic [7:0] mask_nxt  [LSIR_NUM_FRAMERS][2];
  logic [7:0] evt       [LSIR_NUM_FRAMERS][LSIR_NUM_LATCHED];
  logic [3:0] rx_pdv;
  logic [3:0] tx_pdv;
  logic [7:0] summary;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rdata_oe_r;
  logic       rdata_oe_nxt;
  lsir_sel_t  sel;

  // Any address not claimed by a register answers with the summary
  function automatic lsir_sel_t addr_sel(input logic [7:0] a);
    case (a)
      LSIR_ADDR_STAT1:   addr_sel = LSIR_SEL_STAT1;
      LSIR_ADDR_STAT2:   addr_sel = LSIR_SEL_STAT2;
      LSIR_ADDR_RXINFO1: addr_sel = LSIR_SEL_RXINFO1;
      LSIR_ADDR_RXINFO2: addr_sel = LSIR_SEL_RXINFO2;
      LSIR_ADDR_MASK1:   addr_sel = LSIR_SEL_MASK1;
      LSIR_ADDR_MASK2:   addr_sel = LSIR_SEL_MASK2;
      default:           addr_sel = LSIR_SEL_SUMMARY; // R10
    endcase
  endfunction

  assign sel = addr_sel(addr_i);

  // Density monitors, one pair per framer
  genvar g;
  generate
    for (g = 0; g < LSIR_NUM_FRAMERS; g++) begin : g_pd
      lsir_density_chk u_rx_chk ( // R15
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .bit_en_i  (rx_bit_en_i[g]),
        .bit_i     (rx_bit_i[g]),
        .viol_o    (rx_pdv[g])
      );
      lsir_density_chk u_tx_chk ( // R15
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .bit_en_i  (tx_bit_en_i[g]),
        .bit_i     (tx_bit_i[g]),
        .viol_o    (tx_pdv[g])
      );

      // Buffer full, empty, slip, alarm recovery and framing events arrive
      // already qualified by the framer on their own bit positions
      assign evt[g][0] = stat1_evt_i[g*8 +: 8];
      assign evt[g][1] = stat2_evt_i[g*8 +: 8];
      assign evt[g][2] = rxinfo1_evt_i[g*8 +: 8]; // R11 R17
      assign evt[g][3] = {rxinfo2_evt_i[g*LSIR_RXI2_EXT_W +: LSIR_RXI2_EXT_W], // R12 R17
                          rx_pdv[g],  // R13
                          tx_pdv[g]}; // R14

      // Only the status registers feed the summary and the interrupt
      assign summary[2*g]   = |(latch_r[g][0] & mask_r[g][0]); // R8 R9 R10
      assign summary[2*g+1] = |(latch_r[g][1] & mask_r[g][1]); // R8 R9 R10
    end
  endgenerate

  // Latches and readable copies
  always_comb begin
    for (int f = 0; f < LSIR_NUM_FRAMERS; f++) begin
      for (int r = 0; r < LSIR_NUM_LATCHED; r++) begin
        // An event in the clearing cycle survives: set wins over clear
        latch_nxt[f][r] = latch_r[f][r] | evt[f][r]; // R1 R2
        copy_nxt[f][r]  = copy_r[f][r];              // R4
        if (cs_i && wr_i && (fs_i == 2'(f)) && (sel == lsir_sel_t'(3'(r)))) begin // R7
          copy_nxt[f][r]  = (copy_r[f][r] & ~wdata_i)
                          | ((latch_r[f][r] | evt[f][r]) & wdata_i); // R3 R4
          latch_nxt[f][r] = (latch_r[f][r] & ~wdata_i) | evt[f][r]; // R2 R3
        end
      end
    end
  end

  // Mask registers are plain storage
  always_comb begin
    for (int f = 0; f < LSIR_NUM_FRAMERS; f++) begin
      mask_nxt[f][0] = mask_r[f][0];
      mask_nxt[f][1] = mask_r[f][1];
      if (cs_i && wr_i && (fs_i == 2'(f))) begin
        if (sel == LSIR_SEL_MASK1) begin
          mask_nxt[f][0] = wdata_i; // R7 R9
        end
        if (sel == LSIR_SEL_MASK2) begin
          mask_nxt[f][1] = wdata_i; // R7 R9
        end
      end
    end
  end

  // Read path; reading alone never clears anything
  always_comb begin
    rdata_nxt    = rdata_r;
    rdata_oe_nxt = 1'b0;
    if (cs_i && rd_i) begin
      rdata_oe_nxt = 1'b1;
      case (sel)
        LSIR_SEL_STAT1:   rdata_nxt = copy_r[fs_i][0];
        LSIR_SEL_STAT2:   rdata_nxt = copy_r[fs_i][1];
        LSIR_SEL_RXINFO1: rdata_nxt = copy_r[fs_i][2];
        LSIR_SEL_RXINFO2: rdata_nxt = copy_r[fs_i][3];
        LSIR_SEL_MASK1:   rdata_nxt = mask_r[fs_i][0];
        LSIR_SEL_MASK2:   rdata_nxt = mask_r[fs_i][1];
        default:          rdata_nxt = summary; // R10
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int f = 0; f < LSIR_NUM_FRAMERS; f++) begin
        for (int r = 0; r < LSIR_NUM_LATCHED; r++) begin
          latch_r[f][r] <= LSIR_RST_LATCH;
          copy_r[f][r]  <= LSIR_RST_COPY;
        end
        mask_r[f][0] <= LSIR_RST_MASK;
        mask_r[f][1] <= LSIR_RST_MASK;
      end
      rdata_r    <= 8'h00;
      rdata_oe_r <= 1'b0;
    end else begin
      for (int f = 0; f < LSIR_NUM_FRAMERS; f++) begin
        for (int r = 0; r < LSIR_NUM_LATCHED; r++) begin
          latch_r[f][r] <= latch_nxt[f][r];
          copy_r[f][r]  <= copy_nxt[f][r];
        end
        mask_r[f][0] <= mask_nxt[f][0];
        mask_r[f][1] <= mask_nxt[f][1];
      end
      rdata_r    <= rdata_nxt;
      rdata_oe_r <= rdata_oe_nxt;
    end
  end

  assign rdata_o    = rdata_r;
  assign rdata_oe_o = rdata_oe_r;

  // Open drain: pull low while any framer has an unmasked status flag
  assign irq_n_o    = 1'b0;
  assign irq_n_oe_o = |summary; // R16

endmodule

// ==== lsir_regs_asserts.sv ====
// Port-level checks for the latched status and interrupt register bank
`timescale 1ns/10ps
module lsir_regs_asserts
  import lsir_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Control port
  input  wire logic        cs_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  rdata_o,
  input  wire logic        rdata_oe_o,
  // Status events and interrupt
  input  wire logic [31:0] stat1_evt_i,
  input  wire logic [31:0] stat2_evt_i,
  input  wire logic        irq_n_o,
  input  wire logic        irq_n_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic stat_any;
  logic mask_wr;
  assign stat_any = |{stat1_evt_i, stat2_evt_i};
  assign mask_wr  = cs_i && wr_i && (addr_i == LSIR_ADDR_MASK1 || addr_i == LSIR_ADDR_MASK2);
  a_rd_answer: assert property (cs_i && rd_i |=> rdata_oe_o)
    else $error("read produced no data strobe");
  a_oe_cause: assert property (rdata_oe_o |-> $past(cs_i && rd_i))
    else $error("data strobe without a read");
  a_rdata_hold: assert property (!(cs_i && rd_i) |=> $stable(rdata_o))
    else $error("read data changed without a read");
  a_irq_pin_low: assert property (irq_n_o == 1'h0)
    else $error("interrupt pin data not low");
  a_irq_rise: assert property ($rose(irq_n_oe_o) |-> $past(stat_any || mask_wr))
    else $error("interrupt raised without status event or mask write");
  a_irq_fall: assert property ($fell(irq_n_oe_o) |-> $past(cs_i && wr_i))
    else $error("interrupt released without a write");
  a_irq_quiet: assert property (!stat_any && !(cs_i && wr_i) |=> $stable(irq_n_oe_o))
    else $error("interrupt changed with no cause");
  a_oe_pulse: assert property (rdata_oe_o && !(cs_i && rd_i) |=> !rdata_oe_o)
    else $error("data strobe longer than one cycle");
endmodule

// ==== lsir_host_model.sv ====
// Host processor model driving the parallel control port
`timescale 1ns/10ps
module lsir_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Read answer
  input  wire logic [7:0] rdata_i,
  input  wire logic       rdata_oe_i,
  // Requests
  output logic            cs_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [1:0] fs_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    {cs_o, wr_o, rd_o, fs_o, addr_o, wdata_o} = '0;
  end
  task wr(input logic [1:0] f, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    {cs_o, wr_o, fs_o, addr_o, wdata_o} = {2'h3, f, a, d};
    @(negedge clk_sys_i);
    // Idle bus shows the inverse so no stale value can pass as valid
    {cs_o, wr_o, addr_o, wdata_o} = {2'h0, ~a, ~d};
  endtask
  task rd(input logic [1:0] f, input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    {cs_o, rd_o, fs_o, addr_o} = {2'h3, f, a};
    @(negedge clk_sys_i);
    {cs_o, rd_o, addr_o} = {2'h0, ~a};
    d = rdata_i;
    lsir_regs_tb_top.cmp_count++;
    if (rdata_oe_i !== 1'h1) begin
      lsir_regs_tb_top.bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, rdata_oe_i, 1'h1);
    end
  endtask
  // Mask write, read, then write back the masked result
  task poll(input logic [1:0] f, input logic [7:0] a, m, output logic [7:0] d);
    wr(f, a, m);
    rd(f, a, d);
    wr(f, a, d & m);
  endtask
endmodule

// ==== lsir_regs_tb_top.sv ====
// Testbench for the latched status and interrupt register bank
`timescale 1ns/10ps
module lsir_regs_tb_top;
  import lsir_pkg::*;
  logic        clk_sys_i = 1'h0;
  logic        nrst_i, cs, wr, rd, rdata_oe, irq_n, irq_oe;
  logic [1:0]  fs;
  logic [7:0]  addr, wdata, rdata, v;
  logic [31:0] stat1, stat2, rxi1;
  logic [23:0] rxi2;
  logic [3:0]  rx_en, rx_b, tx_en, tx_b;
  int          bad_count = 0;
  int          cmp_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  lsir_regs uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cs_i(cs), .wr_i(wr), .rd_i(rd),
    .fs_i(fs), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_o(rdata_oe),
    .stat1_evt_i(stat1), .stat2_evt_i(stat2), .rxinfo1_evt_i(rxi1), .rxinfo2_evt_i(rxi2),
    .rx_bit_en_i(rx_en), .rx_bit_i(rx_b), .tx_bit_en_i(tx_en), .tx_bit_i(tx_b),
    .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
  lsir_host_model h (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rdata_oe_i(rdata_oe),
    .cs_o(cs), .wr_o(wr), .rd_o(rd), .fs_o(fs), .addr_o(addr), .wdata_o(wdata));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // One bit on framer 3; the stream not under test carries ones
  task dbit(input logic on_rx, input logic b);
    @(negedge clk_sys_i);
    {rx_en, tx_en} = 8'h88;
    rx_b = {on_rx ? b : 1'h1, 3'h7};
    tx_b = {on_rx ? 1'h1 : b, 3'h7};
  endtask
  initial begin
    {stat1, stat2, rxi1, rxi2, rx_en, rx_b, tx_en, tx_b} = '0;
    nrst_i = 1'h0;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i) nrst_i = 1'h1;
    h.rd(2'h0, LSIR_ADDR_RXINFO1, v); chk(v, LSIR_RST_COPY);
    h.rd(2'h0, LSIR_ADDR_MASK1, v); chk(v, LSIR_RST_MASK);
    // Receive buffer full on framer 1, read by hand to see the held copy
    @(negedge clk_sys_i) rxi1[12] = 1'h1;
    @(negedge clk_sys_i) rxi1[12] = 1'h0;
    h.wr(2'h1, LSIR_ADDR_RXINFO1, 8'h10);
    h.rd(2'h1, LSIR_ADDR_RXINFO1, v); chk(v, 8'h10);
    h.wr(2'h1, LSIR_ADDR_RXINFO1, 8'h00);
    h.rd(2'h1, LSIR_ADDR_RXINFO1, v); chk(v, 8'h10);
    h.wr(2'h1, LSIR_ADDR_RXINFO1, 8'h10);
    h.rd(2'h1, LSIR_ADDR_RXINFO1, v); chk(v, 8'h00);
    // Masked status event must stay silent until unmasked
    @(negedge clk_sys_i) stat2[19] = 1'h1;
    @(negedge clk_sys_i) stat2[19] = 1'h0;
    cyc(1); chk({7'h00, irq_oe}, 8'h00);
    h.rd(2'h0, 8'h00, v); chk(v, 8'h00);
    h.wr(2'h2, LSIR_ADDR_MASK2, 8'h08);
    cyc(1); chk({7'h00, irq_oe}, 8'h01);
    h.rd(2'h3, 8'h00, v); chk(v, 8'h20);
    h.rd(2'h2, LSIR_ADDR_MASK2, v); chk(v, 8'h08);
    h.poll(2'h2, LSIR_ADDR_STAT2, 8'h08, v); chk(v, 8'h08);
    cyc(1); chk({7'h00, irq_oe}, 8'h00);
    // Information events never interrupt, even with every bit of framer 0's first mask set
    h.wr(2'h0, LSIR_ADDR_MASK1, 8'hFF);
    @(negedge clk_sys_i) {rxi1[7:0], rxi2[5:0]} = 14'h3FFF;
    @(negedge clk_sys_i) {rxi1, rxi2} = '0;
    cyc(1); chk({7'h00, irq_oe}, 8'h00);
    h.poll(2'h0, LSIR_ADDR_RXINFO2, 8'hFC, v); chk(v, 8'hFC);
    @(negedge clk_sys_i) stat1[0] = 1'h1;
    @(negedge clk_sys_i) stat1[0] = 1'h0;
    cyc(1); chk({7'h00, irq_oe}, 8'h01);
    h.rd(2'h0, 8'hFF, v); chk(v, 8'h01);
    h.poll(2'h0, LSIR_ADDR_STAT1, 8'h01, v); chk(v, 8'h01);
    // Fifteen zeros pass, the sixteenth flags; transmit first, then receive
    for (int s = 0; s < 2; s++) begin
      dbit(s[0], 1'h1);
      repeat (15) dbit(s[0], 1'h0);
      @(negedge clk_sys_i) {rx_en, tx_en} = 8'h00;
      cyc(3); h.poll(2'h3, LSIR_ADDR_RXINFO2, 8'h03, v); chk(v, 8'h00);
      dbit(s[0], 1'h0);
      @(negedge clk_sys_i) {rx_en, tx_en} = 8'h00;
      cyc(3); h.poll(2'h3, LSIR_ADDR_RXINFO2, 8'h03, v); chk(v, s ? 8'h02 : 8'h01);
    end
    // Reset in mid-run drops a pending interrupt and clears masks and copies
    @(negedge clk_sys_i) stat1[1] = 1'h1;
    @(negedge clk_sys_i) stat1[1] = 1'h0;
    cyc(1); chk({7'h00, irq_oe}, 8'h01);
    nrst_i = 1'h0;
    cyc(2);
    nrst_i = 1'h1;
    chk({7'h00, irq_oe}, 8'h00);
    h.rd(2'h0, LSIR_ADDR_MASK1, v); chk(v, LSIR_RST_MASK);
    h.rd(2'h0, LSIR_ADDR_STAT1, v); chk(v, LSIR_RST_COPY);
    report_and_stop();
  end
endmodule
bind lsir_regs lsir_regs_asserts u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .cs_i(cs_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .rdata_o(rdata_o),
  .rdata_oe_o(rdata_oe_o), .stat1_evt_i(stat1_evt_i), .stat2_evt_i(stat2_evt_i),
  .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o));
